// ### hw/option_cfg_pkg.sv
// package: register map, field layout, reset values and timing constants of the option register
package option_cfg_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OPTION_SETTINGS_ADDR = 8'h94;   // byte address, word aligned
  localparam logic [7:0] OPTION_STATUS_ADDR   = 8'h98;   // read-only decoded view
  localparam logic [7:0] OPTION_RESET_VALUE   = 8'h00;

  // ---------------------------------------------------------------------------
  // field positions inside option_settings
  // ---------------------------------------------------------------------------
  localparam int TOUCH_ADJ_BIT  = 6;
  localparam int WDT_SEL_LSB    = 4;
  localparam int ADC_SEL_LSB    = 2;
  localparam int TM3_SEL_LSB    = 0;
  localparam logic [7:0] WRITABLE_MASK = 8'h7F;          // bit 7 lives elsewhere

  // ---------------------------------------------------------------------------
  // watchdog overflow times in ms, and timer3 periods in slow-clock cycles
  // ---------------------------------------------------------------------------
  localparam logic [9:0]  WDT_MS_480 = 10'd480;
  localparam logic [9:0]  WDT_MS_240 = 10'd240;
  localparam logic [9:0]  WDT_MS_120 = 10'd120;
  localparam logic [9:0]  WDT_MS_60  = 10'd60;
  localparam logic [15:0] TM3_CYC_00 = 16'd32768;
  localparam logic [15:0] TM3_CYC_01 = 16'd16384;
  localparam logic [15:0] TM3_CYC_10 = 16'd8192;
  localparam logic [15:0] TM3_CYC_11 = 16'd128;

  // converter clock divisors (sysclk / n)
  localparam logic [5:0] ADC_DIV_00 = 6'd32;
  localparam logic [5:0] ADC_DIV_01 = 6'd16;
  localparam logic [5:0] ADC_DIV_10 = 6'd8;
  localparam logic [5:0] ADC_DIV_11 = 6'd4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       touch_clock_auto_adjust_en;
    logic [1:0] watchdog_period_sel;
    logic [1:0] converter_clock_div_sel;
    logic [1:0] timer3_period_sel;
  } option_fields_t;

  typedef struct packed {
    logic [9:0]  watchdog_period_ms;
    logic [5:0]  converter_clock_div;
    logic [15:0] timer3_period_cycles;
  } option_decoded_t;

endpackage

// ### hw/option_decode.sv
// module: decodes the option fields into registered period and divisor values
`timescale 1ns/100ps
module option_decode (
  input  wire logic                            i_clk,
  input  wire logic                            i_sys_rst,
  input  wire logic                            i_ce,
  input  option_cfg_pkg::option_fields_t       i_fields,
  output option_cfg_pkg::option_decoded_t      o_decoded
);
  import option_cfg_pkg::*;

  typedef struct packed {
    option_decoded_t dec;
  } dec_state_t;

  dec_state_t state_q;
  dec_state_t state_d;

  // table lookups for the three selector fields
  always_comb begin
    state_d = state_q;
    case (i_fields.watchdog_period_sel)
      2'b00:   state_d.dec.watchdog_period_ms = WDT_MS_480;
      2'b01:   state_d.dec.watchdog_period_ms = WDT_MS_240;
      2'b10:   state_d.dec.watchdog_period_ms = WDT_MS_120;
      default: state_d.dec.watchdog_period_ms = WDT_MS_60;
    endcase
    case (i_fields.converter_clock_div_sel)
      2'b00:   state_d.dec.converter_clock_div = ADC_DIV_00;
      2'b01:   state_d.dec.converter_clock_div = ADC_DIV_01;
      2'b10:   state_d.dec.converter_clock_div = ADC_DIV_10;
      default: state_d.dec.converter_clock_div = ADC_DIV_11;
    endcase
    case (i_fields.timer3_period_sel)
      2'b00:   state_d.dec.timer3_period_cycles = TM3_CYC_00;
      2'b01:   state_d.dec.timer3_period_cycles = TM3_CYC_01;
      2'b10:   state_d.dec.timer3_period_cycles = TM3_CYC_10;
      default: state_d.dec.timer3_period_cycles = TM3_CYC_11;
    endcase
  end

  // reset value equals the decode of all-zero fields
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= '{dec: '{watchdog_period_ms: WDT_MS_480, converter_clock_div: ADC_DIV_00,
                         timer3_period_cycles: TM3_CYC_00}};
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  assign o_decoded = state_q.dec;
endmodule

// ### hw/option_settings_regs.sv
// module: option settings register behind an AXI4-Lite slave
//
// Behaviour
// - bit 6 enables touch clock auto adjust
// - bits 5:4 pick watchdog 480/240/120/60 ms
// - bits 3:2 pick converter clock divide 32..4
// - bits 1:0 pick timer3 period 32768..128 cycles
`timescale 1ns/100ps
module option_settings_regs (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_ce,
  // AXI4-Lite write address / data / response
  input  wire logic [7:0]                  i_awaddr,
  input  wire logic                        i_awvalid,
  output logic                             o_awready,
  input  wire logic [31:0]                 i_wdata,
  input  wire logic [3:0]                  i_wstrb,
  input  wire logic                        i_wvalid,
  output logic                             o_wready,
  output logic [1:0]                       o_bresp,
  output logic                             o_bvalid,
  input  wire logic                        i_bready,
  // AXI4-Lite read address / data
  input  wire logic [7:0]                  i_araddr,
  input  wire logic                        i_arvalid,
  output logic                             o_arready,
  output logic [31:0]                      o_rdata,
  output logic [1:0]                       o_rresp,
  output logic                             o_rvalid,
  input  wire logic                        i_rready,
  // settings toward the consuming blocks
  output logic                             o_touch_clock_auto_adjust_en,
  output logic [1:0]                       o_watchdog_period_sel,
  output logic [1:0]                       o_converter_clock_div_sel,
  output logic [1:0]                       o_timer3_period_sel,
  output option_cfg_pkg::option_decoded_t  o_decoded
);
  import option_cfg_pkg::*;

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  opt;        // option_settings, bit 7 held at zero
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic        w_strb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } regs_state_t;

  regs_state_t     state_q;
  regs_state_t     state_d;
  option_fields_t  fields;
  option_decoded_t decoded;

  // ---------------------------------------------------------------------------
  // field view and decode
  // ---------------------------------------------------------------------------
  // fields drawn straight from the stored byte
  always_comb begin
    fields.touch_clock_auto_adjust_en = state_q.opt[TOUCH_ADJ_BIT];
    fields.watchdog_period_sel        = state_q.opt[WDT_SEL_LSB +: 2];
    fields.converter_clock_div_sel    = state_q.opt[ADC_SEL_LSB +: 2];
    fields.timer3_period_sel          = state_q.opt[TM3_SEL_LSB +: 2];
  end

  option_decode u_decode (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_fields  (fields),
    .o_decoded (decoded)
  );

  // ---------------------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------------------
  // address and data latched separately so either may arrive first;
  // ready is low while a beat is held, so at most one write waits behind a pending response
  always_comb begin
    state_d = state_q;
    if (i_awvalid && !state_q.aw_held) begin
      state_d.aw_held = 1'b1;
      state_d.aw_addr = i_awaddr;
    end
    if (i_wvalid && !state_q.w_held) begin
      state_d.w_held  = 1'b1;
      state_d.w_data  = i_wdata;
      state_d.w_strb0 = i_wstrb[0];
    end
    // commit when both halves are held and no response is pending
    if (state_q.aw_held && state_q.w_held && !state_q.bvalid) begin
      state_d.aw_held = 1'b0;
      state_d.w_held  = 1'b0;
      state_d.bvalid  = 1'b1;
      if (state_q.aw_addr == OPTION_SETTINGS_ADDR) begin
        state_d.bresp = RESP_OKAY;
        if (state_q.w_strb0) begin
          state_d.opt = state_q.w_data[7:0] & WRITABLE_MASK;
        end
      end else if (state_q.aw_addr == OPTION_STATUS_ADDR) begin
        state_d.bresp = RESP_OKAY;                                         // status ignores writes
      end else begin
        state_d.bresp = RESP_SLVERR;
      end
    end
    if (state_q.bvalid && i_bready) begin
      state_d.bvalid = 1'b0;
    end
    // read: answer one cycle after the address is taken
    if (i_arvalid && !state_q.rvalid) begin
      state_d.rvalid = 1'b1;
      state_d.rresp  = RESP_OKAY;
      case (i_araddr)
        OPTION_SETTINGS_ADDR: state_d.rdata = {24'h00_0000, state_q.opt};
        OPTION_STATUS_ADDR:   state_d.rdata = {decoded.watchdog_period_ms, decoded.converter_clock_div,
                                               decoded.timer3_period_cycles};
        default: begin
          state_d.rdata = 32'h0000_0000;
          state_d.rresp = RESP_SLVERR;
        end
      endcase
    end else if (state_q.rvalid && i_rready) begin
      state_d.rvalid = 1'b0;
    end
  end

  // all state frozen while the clock enable is low
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q     <= '0;
      state_q.opt <= OPTION_RESET_VALUE;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------------------
  assign o_awready = ~state_q.aw_held;
  assign o_wready  = ~state_q.w_held;
  assign o_bvalid  = state_q.bvalid;
  assign o_bresp   = state_q.bresp;
  assign o_arready = ~state_q.rvalid;
  assign o_rvalid  = state_q.rvalid;
  assign o_rdata   = state_q.rdata;
  assign o_rresp   = state_q.rresp;
  assign o_touch_clock_auto_adjust_en = state_q.opt[TOUCH_ADJ_BIT];
  assign o_watchdog_period_sel        = state_q.opt[WDT_SEL_LSB +: 2];
  assign o_converter_clock_div_sel    = state_q.opt[ADC_SEL_LSB +: 2];
  assign o_timer3_period_sel          = state_q.opt[TM3_SEL_LSB +: 2];
  assign o_decoded                    = decoded;
endmodule

// ### verification/option_regs_props.sv
// checker: setting outputs and their decoded values
`timescale 1ns/100ps
module option_regs_props (
  input  wire logic                             i_clk,
  input  wire logic                             i_sys_rst,
  input  wire logic                             i_ce,
  input  wire logic                             o_bvalid,
  input  wire logic                             o_touch_clock_auto_adjust_en,
  input  wire logic [1:0]                       o_watchdog_period_sel,
  input  wire logic [1:0]                       o_converter_clock_div_sel,
  input  wire logic [1:0]                       o_timer3_period_sel,
  input  wire option_cfg_pkg::option_decoded_t  o_decoded
);
  import option_cfg_pkg::*;
  // -------------------------------------------------------------------------
  // expected decode tables
  // -------------------------------------------------------------------------
  localparam logic [9:0]  MS [4] = '{10'd480, 10'd240, 10'd120, 10'd60};
  localparam logic [5:0]  DV [4] = '{6'd32, 6'd16, 6'd8, 6'd4};
  localparam logic [15:0] CY [4] = '{16'd32768, 16'd16384, 16'd8192, 16'd128};
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // settings move only with a write commit
  property p_fields_hold;
    !$rose(o_bvalid) |-> $stable({o_touch_clock_auto_adjust_en, o_watchdog_period_sel,
                                  o_converter_clock_div_sel, o_timer3_period_sel});
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("settings changed without a write");
  property p_wdt;
    i_ce |=> o_decoded.watchdog_period_ms == MS[$past(o_watchdog_period_sel)];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog period decode wrong");
  property p_adc;
    i_ce |=> o_decoded.converter_clock_div == DV[$past(o_converter_clock_div_sel)];
  endproperty
  a_adc: assert property (p_adc) else $error("converter divisor decode wrong");
  property p_tm3;
    i_ce |=> o_decoded.timer3_period_cycles == CY[$past(o_timer3_period_sel)];
  endproperty
  a_tm3: assert property (p_tm3) else $error("timer3 period decode wrong");
  c_touch: cover property ($rose(o_touch_clock_auto_adjust_en));
  c_wdt3: cover property (o_watchdog_period_sel == 2'h3);
  c_tm3: cover property (o_timer3_period_sel == 2'h2);
endmodule
bind option_settings_regs option_regs_props u_props (.i_clk, .i_sys_rst, .i_ce, .o_bvalid,
  .o_touch_clock_auto_adjust_en, .o_watchdog_period_sel, .o_converter_clock_div_sel,
  .o_timer3_period_sel, .o_decoded);

// ### verification/tb.sv
// testbench: bus accesses to the option register and its setting outputs
`timescale 1ns/100ps
module tb;
  import option_cfg_pkg::*;
  logic        i_clk, i_sys_rst, i_ce, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_touch_clock_auto_adjust_en;
  logic [7:0]  i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp, o_watchdog_period_sel, o_converter_clock_div_sel, o_timer3_period_sel, rs, c;
  option_decoded_t o_decoded;
  int          errors, check_count;
  logic [9:0]  ms [4] = '{10'd480, 10'd240, 10'd120, 10'd60};
  logic [5:0]  dv [4] = '{6'd32, 6'd16, 6'd8, 6'd4};
  logic [15:0] cy [4] = '{16'd32768, 16'd16384, 16'd8192, 16'd128};
  option_settings_regs uut (.i_clk, .i_sys_rst, .i_ce, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .o_touch_clock_auto_adjust_en, .o_watchdog_period_sel, .o_converter_clock_div_sel,
    .o_timer3_period_sel, .o_decoded);
  // -------------------------------------------------------------------------
  // bus tasks; request held until its own ready is sampled high
  // -------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_awready && i_awvalid) i_awvalid <= 1'b0;
      if (o_wready && i_wvalid) i_wvalid <= 1'b0;
    end while (!o_bvalid);
    rs = o_bresp;
    i_bready <= 1'b0;
  endtask
  task automatic rdreg(input logic [7:0] a);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_arready && i_arvalid) i_arvalid <= 1'b0;
    end while (!o_rvalid);
    rd = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // 100 ns clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // whole run is about 70 cycles; the 10000-cycle limit is over a hundred times that
  initial begin
    #1_000_000;
    errors++;
    final_report;
  end
  // -------------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------------
  initial begin
    {i_sys_rst, i_ce} = 2'h3;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = 52'h0;
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rdreg(OPTION_SETTINGS_ADDR);
    chk(rd, 32'h0000_0000, "reset value");
    chk(32'(o_decoded), {ms[0], dv[0], cy[0]}, "reset decode");
    $display("test reset done");
    // every code of every field; bit 7 set to see it dropped
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      wr(OPTION_SETTINGS_ADDR, {24'h00_0000, 1'b1, c[0], c, c, c}, 4'hF);
      chk(32'(rs), 32'(RESP_OKAY), "write response");
      chk(32'({o_touch_clock_auto_adjust_en, o_watchdog_period_sel, o_converter_clock_div_sel,
               o_timer3_period_sel}), 32'({c[0], c, c, c}), "setting outputs");
      rdreg(OPTION_SETTINGS_ADDR);
      chk(rd, {24'h00_0000, 1'b0, c[0], c, c, c}, "readback");
      chk(32'(o_decoded), {ms[c], dv[c], cy[c]}, "decoded outputs");
      rdreg(OPTION_STATUS_ADDR);
      chk(rd, {ms[c], dv[c], cy[c]}, "decoded readback");
    end
    $display("test field codes done");
    // strobe off, then unmapped write and read
    wr(OPTION_SETTINGS_ADDR, 32'h0000_0000, 4'h0);
    chk(32'(o_touch_clock_auto_adjust_en), 32'h0000_0001, "strobe-off write took effect");
    // status view answers okay but must keep the settings byte untouched
    wr(OPTION_STATUS_ADDR, 32'h0000_0000, 4'hF);
    chk(32'(rs), 32'(RESP_OKAY), "status write response");
    chk(32'(o_watchdog_period_sel), 32'h0000_0003, "status write changed a setting");
    wr(8'h10, 32'h0000_0000, 4'hF);
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped write response");
    rdreg(8'h10);
    chk(rd, 32'h0000_0000, "unmapped read data");
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped read response");
    rdreg(OPTION_SETTINGS_ADDR);
    chk(rd, 32'h0000_007F, "value after refusals");
    $display("test refusals done");
    final_report;
  end
endmodule
